// *** bench/lcdfc_asserts.sv ***
// Checker of bus answers and scan outputs of the frame clock block
`timescale 1ns/1ps
module lcdfc_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] com_out,
  input wire logic frame_pulse
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Decoded request kinds, seen in the setup cycle
  wire setup = psel && !penable;
  wire wo_rd = setup && !pwrite && paddr[1:0] == 2'h0 && paddr[11:2] >= 10'h01B && paddr[11:2] <= 10'h01F;
  wire mis = setup && paddr[1:0] != 2'h0;
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no answer after setup");
  a_ready_in_access: assert property (pready |-> $past(setup) && psel && penable)
    else $error("answer outside access");
  a_err_needs_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_misalign_refused: assert property (mis |=> pslverr && prdata == 32'h0)
    else $error("misaligned access taken");
  a_wo_read_zero: assert property (wo_rd |=> !pslverr && prdata == 32'h0)
    else $error("write-only register read back");
  a_com_one_hot: assert property ($onehot0(com_out))
    else $error("two commons active");
  a_pulse_one_cycle: assert property (frame_pulse |=> !frame_pulse)
    else $error("frame pulse too long");
endmodule
bind lcdfc_top lcdfc_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .com_out, .frame_pulse);

// *** bench/lcdfc_panel.sv ***
// Behavioural panel that records segment one as seen under each common
`timescale 1ns/1ps
module lcdfc_panel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] com_out,
  input wire logic seg_one,
  output logic [3:0] seg1_lit
);
  // Only a driven common refreshes its cell, so stale cells keep the old state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg1_lit <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (com_out[k]) seg1_lit[k] <= seg_one;
      end
    end
  end
endmodule

// *** bench/tb.sv ***
// Testbench: register access, pin selection, blanking and frame rate
`timescale 1ns/1ps
`include "lcdfc_defines.svh"
module tb;
  import lcdfc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic subclk_pin = 1'b0, low_power_mode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, power_switch, frame_pulse, rerr;
  logic [3:0] com_out, seg1_lit;
  logic [51:0] seg_out;
  logic [19:0] seg_pin_select;
  int mismatches = 0;
  int samples_checked = 0;
  int sc = 0;
  int n;
  int dv [4] = '{16, 4, 8, 16};
  always #5 pclk = ~pclk;
  // Subclock at an eighth of pclk so each edge crosses the synchroniser cleanly
  always @(posedge pclk) begin
    sc <= (sc + 1) % 4;
    if (sc == 3) subclk_pin <= ~subclk_pin;
  end
  // Small dividers keep every frame short
  lcdfc_top #(.DIV_CL1(4), .DIV_CL2(8), .DIV_CL3(16), .DIV_SUB0(2), .DIV_SUB3(4)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .subclk_pin, .low_power_mode, .com_out,
    .seg_out, .seg_pin_select, .power_switch, .frame_pulse);
  lcdfc_panel panel (.pclk, .presetn, .com_out, .seg_one(seg_out[0]), .seg1_lit);
  task automatic finish_test();
    $display("compared %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'h0}, d);
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask
  // Counts edges up to the next frame pulse
  task automatic pw();
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (frame_pulse !== 1'b1 && n < 3000);
    if (frame_pulse !== 1'b1) begin
      mismatches++;
      finish_test();
    end
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk("pin select", 32'(seg_pin_select), 32'h0);
    chk("power switch", 32'(power_switch), 32'h0);
    for (int i = 'h1B; i <= 'h1F; i++) begin
      apb(1'b0, {10'(i), 2'h0}, 32'h0);
      chk("wo read", rdat, 32'h0);
    end
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped err", 32'(rerr), 32'h1);
    apb(1'b0, 12'h076, 32'h0);
    chk("misaligned err", 32'(rerr), 32'h1);
    wr(`LCDFC_IDX_SEG_P4, 32'hA);
    wr(`LCDFC_IDX_SEG_P5, 32'h5);
    wr(`LCDFC_IDX_SEG_GRP, 32'hF);
    settle();
    chk("pin select", 32'(seg_pin_select), 32'hFFF5A);
    wr(`LCDFC_IDX_SEG_GRP, 32'hA);
    settle();
    chk("group select", 32'(seg_pin_select), 32'h0F05A);
    $display("register test done");
    wr(`LCDFC_IDX_DISP_CTRL, 32'h2);
    wr(`LCDFC_IDX_RAM_FIRST, 32'hF);
    wr(`LCDFC_IDX_DUTY_CLK, 32'h7);
    repeat (3) pw();
    chk("blank segs", seg_out[31:0], 32'h0);
    chk("power on", 32'(power_switch), 32'h1);
    wr(`LCDFC_IDX_DISP_CTRL, 32'h3);
    repeat (3) pw();
    chk("seg out", seg_out[31:0], 32'h1);
    chk("panel seg one", 32'(seg1_lit), 32'h1);
    @(posedge pclk);
    low_power_mode <= 1'b1;
    settle();
    chk("low power com", 32'(com_out), 32'h0);
    chk("low power switch", 32'(power_switch), 32'h0);
    @(posedge pclk);
    low_power_mode <= 1'b0;
    wr(`LCDFC_IDX_DISP_CTRL, 32'h1);
    settle();
    chk("switch off", 32'(power_switch), 32'h0);
    $display("display test done");
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        wr(`LCDFC_IDX_DUTY_CLK, 32'(s * 4 + d));
        repeat (3) pw();
        chk("frame period", n, 32'(dv[s] * (4 - d)));
      end
    end
    wr(`LCDFC_IDX_TIMER_A, 32'h8);
    for (int d = 0; d < 4; d++) begin
      wr(`LCDFC_IDX_DUTY_CLK, 32'(12 + d));
      repeat (3) pw();
      chk("sub frame period", n, 32'(32 * (4 - d)));
    end
    $display("frame test done");
    finish_test();
  end
endmodule

// *** src/lcdfc_defines.svh ***
// Register indices, field positions, reset values and divider counts of the frame clock block
`ifndef LCDFC_DEFINES_SVH
`define LCDFC_DEFINES_SVH
`define LCDFC_IDX_DISP_CTRL 10'h01B
`define LCDFC_IDX_DUTY_CLK 10'h01C
`define LCDFC_IDX_SEG_P4 10'h01D
`define LCDFC_IDX_SEG_P5 10'h01E
`define LCDFC_IDX_SEG_GRP 10'h01F
`define LCDFC_IDX_RAM_FIRST 10'h050
`define LCDFC_IDX_RAM_LAST 10'h083
`define LCDFC_IDX_TIMER_A 10'h090
`define LCDFC_IDX_STATUS 10'h091
`define LCDFC_DISP_ON_BIT 0
`define LCDFC_PWR_SW_BIT 1
`define LCDFC_LP_KEEP_BIT 2
`define LCDFC_SUBDIV_SEL_BIT 3
`define LCDFC_RST_DISP_CTRL 3'h0
`define LCDFC_RST_DUTY_CLK 4'h0
`define LCDFC_RST_SEG 4'h0
`define LCDFC_RST_TIMER_A 4'h0
`define LCDFC_DIV_CL0_SUB 64
`define LCDFC_DIV_CL1_OSC 1024
`define LCDFC_DIV_CL2_OSC 8192
`define LCDFC_DIV_CL3_OSC 16384
`define LCDFC_DIV_CL3_SUB 512
`define LCDFC_NUM_SEG 52
`define LCDFC_NUM_SHARED 20
`endif

// *** src/lcdfc_pkg.sv ***
// Types shared by the frame clock and segment multiplexer block
package lcdfc_pkg;
  // Common phase, Gray coded along the scan order
  typedef enum logic [1:0] {
    LCDFC_PH0 = 2'h0,
    LCDFC_PH1 = 2'h1,
    LCDFC_PH2 = 2'h3,
    LCDFC_PH3 = 2'h2
  } lcdfc_phase_t;
  // Duty selection as written into the low two bits of the duty/clock register
  typedef enum logic [1:0] {
    LCDFC_DUTY_QUARTER = 2'h0,
    LCDFC_DUTY_THIRD = 2'h1,
    LCDFC_DUTY_HALF = 2'h2,
    LCDFC_DUTY_STATIC = 2'h3
  } lcdfc_duty_t;
  // Frame clock source selection from the upper two bits
  typedef enum logic [1:0] {
    LCDFC_SRC_ZERO = 2'h0,
    LCDFC_SRC_ONE = 2'h1,
    LCDFC_SRC_TWO = 2'h2,
    LCDFC_SRC_THREE = 2'h3
  } lcdfc_src_t;
endpackage

// *** src/lcdfc_top.sv ***
// LCD frame clock generator, display RAM, segment scan and shared pin selection with an APB slave
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "lcdfc_defines.svh"

// Behaviour
// R1 - Timer mode bit 3 chooses which divider feeds the slowest frame clock source.
// R2 - With that bit clear, slowest source is oscillator times duty over 16384.
// R3 - With that bit set, slowest source is subclock times duty over 512.
// R4 - First segment select register, write-only, bitwise turns port-four pins into segments 1-4.
// R5 - First segment select register resets to zero, pins start as ports.
// R6 - Second segment select register, write-only, bitwise turns port-five pins into segments 5-8.
// R7 - Group register bits 0-2 switch whole groups to segments 9-20; bit 3 unused.
// R8 - Software turns the power switch off before changing the drive voltage.
// R9 - Display control register is three write-only bits: blank, power switch, low-power display.
// R10 - Blanking forces every segment signal off regardless of display RAM.
// R11 - Duty/clock register: four write-only bits, upper pair source, lower pair duty.
// R12 - Display RAM writes reach the segment pins automatically, one bit per common.
// R13 - Source codes 00 to 11 pick frame clock sources zero to three.
// R14 - Frame rate scales with duty: static, half, third or quarter of source rate.
module lcdfc_top
  import lcdfc_pkg::*;
#(
  parameter int DIV_CL1 = `LCDFC_DIV_CL1_OSC,
  parameter int DIV_CL2 = `LCDFC_DIV_CL2_OSC,
  parameter int DIV_CL3 = `LCDFC_DIV_CL3_OSC,
  parameter int DIV_SUB0 = `LCDFC_DIV_CL0_SUB,
  parameter int DIV_SUB3 = `LCDFC_DIV_CL3_SUB
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic subclk_pin,
  input wire logic low_power_mode,
  output logic [3:0] com_out,
  output logic [`LCDFC_NUM_SEG-1:0] seg_out,
  output logic [`LCDFC_NUM_SHARED-1:0] seg_pin_select,
  output logic power_switch,
  output logic frame_pulse
);
  localparam int OCW = $clog2(DIV_CL3);
  localparam int SCW = $clog2(DIV_SUB3);

  // True on the last count of a divide-by-div window of a free-running counter
  function automatic logic div_wrap(input logic [31:0] cnt, input int div);
    div_wrap = ((cnt + 32'h1) % div) == 32'h0;
  endfunction

  // Phase index to Gray state and back
  function automatic lcdfc_phase_t ph_of(input logic [1:0] idx);
    case (idx)
      2'h0: ph_of = LCDFC_PH0;
      2'h1: ph_of = LCDFC_PH1;
      2'h2: ph_of = LCDFC_PH2;
      default: ph_of = LCDFC_PH3;
    endcase
  endfunction

  function automatic logic [1:0] idx_of(input lcdfc_phase_t ph);
    case (ph)
      LCDFC_PH0: idx_of = 2'h0;
      LCDFC_PH1: idx_of = 2'h1;
      LCDFC_PH2: idx_of = 2'h2;
      default: idx_of = 2'h3;
    endcase
  endfunction

  // Register state
  logic [2:0] disp_ctrl_r, disp_ctrl_nxt;
  logic [3:0] duty_clk_r, duty_clk_nxt;
  logic [3:0] seg_p4_r, seg_p4_nxt;
  logic [3:0] seg_p5_r, seg_p5_nxt;
  logic [2:0] seg_grp_r, seg_grp_nxt;
  logic [3:0] timer_a_r, timer_a_nxt;
  logic [3:0] ram_r [`LCDFC_NUM_SEG];
  logic [3:0] ram_nxt [`LCDFC_NUM_SEG];
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  logic [9:0] idx;
  logic setup_ph, wr_take, aligned;
  logic [9:0] ram_off;

  assign idx = paddr[11:2];
  assign aligned = paddr[1:0] == 2'h0;
  assign setup_ph = psel & ~penable;
  // Writes land only at the access edge the slave itself marked ready
  assign wr_take = psel & penable & pready_r & pwrite & ~pslverr_r & pstrb[0];
  assign ram_off = idx - `LCDFC_IDX_RAM_FIRST;

  // Decode: known register index at a word-aligned address
  function automatic logic is_mapped(input logic [9:0] i, input logic al);
    is_mapped = al && ((i >= `LCDFC_IDX_DISP_CTRL && i <= `LCDFC_IDX_SEG_GRP) ||
                       (i >= `LCDFC_IDX_RAM_FIRST && i <= `LCDFC_IDX_RAM_LAST) ||
                       i == `LCDFC_IDX_TIMER_A || i == `LCDFC_IDX_STATUS);
  endfunction

  // Status word built from live scan state
  logic [7:0] frame_cnt_r, frame_cnt_nxt;
  lcdfc_phase_t phase_r, phase_nxt;
  logic sub_lvl_r, sub_lvl_nxt;

  // Bus answer prepared in the setup cycle so the access phase never waits
  always_comb begin
    pready_nxt = setup_ph;
    pslverr_nxt = setup_ph & ~is_mapped(idx, aligned);
    prdata_nxt = 32'h0;
    if (setup_ph && !pwrite && is_mapped(idx, aligned)) begin
      if (idx >= `LCDFC_IDX_RAM_FIRST && idx <= `LCDFC_IDX_RAM_LAST) begin
        prdata_nxt = {28'h0, ram_r[ram_off[5:0]]};
      end else if (idx == `LCDFC_IDX_STATUS) begin
        prdata_nxt = {16'h0, frame_cnt_r, 5'h0, sub_lvl_r, idx_of(phase_r)};
      end
    end
  end

  // Control registers; write-only ones read back as zero
  always_comb begin
    disp_ctrl_nxt = disp_ctrl_r;
    duty_clk_nxt = duty_clk_r;
    seg_p4_nxt = seg_p4_r;
    seg_p5_nxt = seg_p5_r;
    seg_grp_nxt = seg_grp_r;
    timer_a_nxt = timer_a_r;
    for (int i = 0; i < `LCDFC_NUM_SEG; i++) begin
      ram_nxt[i] = ram_r[i];
    end
    if (wr_take) begin
      case (idx)
        `LCDFC_IDX_DISP_CTRL: disp_ctrl_nxt = pwdata[2:0]; // R9
        `LCDFC_IDX_DUTY_CLK: duty_clk_nxt = pwdata[3:0]; // R11
        `LCDFC_IDX_SEG_P4: seg_p4_nxt = pwdata[3:0]; // R4
        `LCDFC_IDX_SEG_P5: seg_p5_nxt = pwdata[3:0]; // R6
        `LCDFC_IDX_SEG_GRP: seg_grp_nxt = pwdata[2:0]; // R7
        `LCDFC_IDX_TIMER_A: timer_a_nxt = pwdata[3:0];
        default: begin
          if (idx >= `LCDFC_IDX_RAM_FIRST && idx <= `LCDFC_IDX_RAM_LAST) begin
            ram_nxt[ram_off[5:0]] = pwdata[3:0]; // R12
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_ctrl_r <= `LCDFC_RST_DISP_CTRL;
      duty_clk_r <= `LCDFC_RST_DUTY_CLK;
      seg_p4_r <= `LCDFC_RST_SEG; // R5
      seg_p5_r <= `LCDFC_RST_SEG;
      seg_grp_r <= 3'(`LCDFC_RST_SEG);
      timer_a_r <= `LCDFC_RST_TIMER_A;
      for (int i = 0; i < `LCDFC_NUM_SEG; i++) begin
        ram_r[i] <= 4'h0;
      end
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      disp_ctrl_r <= disp_ctrl_nxt;
      duty_clk_r <= duty_clk_nxt;
      seg_p4_r <= seg_p4_nxt;
      seg_p5_r <= seg_p5_nxt;
      seg_grp_r <= seg_grp_nxt;
      timer_a_r <= timer_a_nxt;
      for (int i = 0; i < `LCDFC_NUM_SEG; i++) begin
        ram_r[i] <= ram_nxt[i];
      end
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Subclock synchroniser
  // Three stages; a change is believed only once stages two and three agree
  logic [2:0] sub_sync_r, sub_sync_nxt;
  logic sub_rise;
  logic [SCW-1:0] sub_cnt_r, sub_cnt_nxt;
  logic [OCW-1:0] osc_cnt_r, osc_cnt_nxt;

  always_comb begin
    sub_sync_nxt = {sub_sync_r[1:0], subclk_pin};
    sub_lvl_nxt = sub_lvl_r;
    if (sub_sync_r[1] == sub_sync_r[2]) begin
      sub_lvl_nxt = sub_sync_r[2];
    end
  end

  assign sub_rise = sub_lvl_nxt & ~sub_lvl_r;

  // Free-running dividers; one counter per clock keeps all taps phase-aligned
  always_comb begin
    osc_cnt_nxt = OCW'(32'(osc_cnt_r) + 32'h1);
    if (div_wrap(32'(osc_cnt_r), DIV_CL3)) begin
      osc_cnt_nxt = '0;
    end
    sub_cnt_nxt = sub_cnt_r;
    if (sub_rise) begin
      sub_cnt_nxt = SCW'(32'(sub_cnt_r) + 32'h1);
      if (div_wrap(32'(sub_cnt_r), DIV_SUB3)) begin
        sub_cnt_nxt = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_sync_r <= 3'h0;
      sub_lvl_r <= 1'b0;
      osc_cnt_r <= '0;
      sub_cnt_r <= '0;
    end else begin
      sub_sync_r <= sub_sync_nxt;
      sub_lvl_r <= sub_lvl_nxt;
      osc_cnt_r <= osc_cnt_nxt;
      sub_cnt_r <= sub_cnt_nxt;
    end
  end

  // Common phase scan
  // One tick per common phase, so a frame of N phases runs at source rate over N
  lcdfc_src_t src_sel;
  lcdfc_duty_t duty_sel;
  logic phase_tick;
  logic [1:0] last_idx;
  logic lp_dark;
  logic [3:0] com_nxt_v;
  logic [`LCDFC_NUM_SEG-1:0] seg_nxt_v;
  logic [`LCDFC_NUM_SHARED-1:0] pin_sel_nxt;
  logic frame_nxt;
  logic [3:0] com_r;
  logic [`LCDFC_NUM_SEG-1:0] seg_r;
  logic [`LCDFC_NUM_SHARED-1:0] pin_sel_r;
  logic pwr_r, frame_r;
  logic pwr_nxt;

  assign src_sel = lcdfc_src_t'(duty_clk_r[3:2]);
  assign duty_sel = lcdfc_duty_t'(duty_clk_r[1:0]);
  // Low-power modes without the keep-on bit ground the panel and open the switch
  assign lp_dark = low_power_mode & ~disp_ctrl_r[`LCDFC_LP_KEEP_BIT];

  always_comb begin
    case (src_sel) // R13
      LCDFC_SRC_ZERO: phase_tick = sub_rise & div_wrap(32'(sub_cnt_r), DIV_SUB0);
      LCDFC_SRC_ONE: phase_tick = div_wrap(32'(osc_cnt_r), DIV_CL1);
      LCDFC_SRC_TWO: phase_tick = div_wrap(32'(osc_cnt_r), DIV_CL2);
      default: begin
        if (timer_a_r[`LCDFC_SUBDIV_SEL_BIT]) begin // R1
          phase_tick = sub_rise & div_wrap(32'(sub_cnt_r), DIV_SUB3); // R3
        end else begin
          phase_tick = div_wrap(32'(osc_cnt_r), DIV_CL3); // R2
        end
      end
    endcase
    case (duty_sel) // R14
      LCDFC_DUTY_STATIC: last_idx = 2'h0;
      LCDFC_DUTY_HALF: last_idx = 2'h1;
      LCDFC_DUTY_THIRD: last_idx = 2'h2;
      default: last_idx = 2'h3;
    endcase
  end

  // Phase advance and frame counting; a duty change that leaves the phase past the new last phase restarts at phase zero
  always_comb begin
    phase_nxt = phase_r;
    frame_cnt_nxt = frame_cnt_r;
    frame_nxt = 1'b0;
    if (idx_of(phase_r) > last_idx) begin
      phase_nxt = LCDFC_PH0;
    end else if (phase_tick) begin
      if (idx_of(phase_r) == last_idx) begin
        phase_nxt = LCDFC_PH0; // R14
        frame_nxt = 1'b1;
        frame_cnt_nxt = frame_cnt_r + 8'h01;
      end else begin
        phase_nxt = ph_of(idx_of(phase_r) + 2'h1);
      end
    end
  end

  // Drive levels for the present phase from live RAM contents
  always_comb begin
    com_nxt_v = 4'h0;
    seg_nxt_v = '0;
    if (!lp_dark) begin
      com_nxt_v[idx_of(phase_nxt)] = 1'b1;
      for (int s = 0; s < `LCDFC_NUM_SEG; s++) begin
        seg_nxt_v[s] = ram_r[s][idx_of(phase_nxt)] & disp_ctrl_r[`LCDFC_DISP_ON_BIT]; // R12 R10
      end
    end
    pin_sel_nxt = {{4{seg_grp_r[2]}}, {4{seg_grp_r[1]}}, {4{seg_grp_r[0]}}, seg_p5_r, seg_p4_r}; // R4 R6 R7
    pwr_nxt = disp_ctrl_r[`LCDFC_PWR_SW_BIT] & ~lp_dark; // R9
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= LCDFC_PH0;
      frame_cnt_r <= 8'h00;
      frame_r <= 1'b0;
      com_r <= 4'h0;
      seg_r <= '0;
      pin_sel_r <= '0;
      pwr_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      frame_cnt_r <= frame_cnt_nxt;
      frame_r <= frame_nxt;
      com_r <= com_nxt_v;
      seg_r <= seg_nxt_v;
      pin_sel_r <= pin_sel_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign com_out = com_r;
  assign seg_out = seg_r;
  assign seg_pin_select = pin_sel_r;
  assign power_switch = pwr_r;
  assign frame_pulse = frame_r;
endmodule
